// *** cmcs_pkg.sv ***
// package: constants and types for the cell monitor conversion sequencer
// What this block does
// - six cells via high mux, then auxiliary
// - return to first cell, then accept start
// - self-test converts band-gap on 0-5 range
// - self-test code near 970-990, readable normally
// - a normal start converts all six cell channels; self-test converts band-gap only
// - count field picks six, three, no auxiliaries
// - readback count field independent of conversions
// - alert field excludes fifth, third auxiliaries
// - shutdown falling edge stops conversions and drops low mux; high mux comes on at the top cell
// - acquisition field selects 400-1600 ns
package cmcs_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] CMCS_ADDR_CTRL    = 4'h0;
    localparam logic [3:0] CMCS_ADDR_ALERT   = 4'h1;
    localparam logic [3:0] CMCS_ADDR_STATUS  = 4'h2;
    localparam logic [3:0] CMCS_ADDR_RESULT  = 4'h3;
    localparam logic [3:0] CMCS_ADDR_CMD     = 4'h4;
    localparam logic [15:0] CMCS_CTRL_RST    = 16'h0000;
    localparam logic [15:0] CMCS_ALERT_RST   = 16'h0000;
    localparam int CMCS_CNT_MSB   = 15;
    localparam int CMCS_CNT_LSB   = 14;
    localparam int CMCS_RDB_MSB   = 13;
    localparam int CMCS_RDB_LSB   = 12;
    localparam int CMCS_ACQ_MSB   = 6;
    localparam int CMCS_ACQ_LSB   = 5;
    localparam int CMCS_TERM_BIT  = 3;
    localparam int CMCS_CMD_START = 0;
    localparam int CMCS_CMD_TEST  = 1;
    localparam logic [1:0] CMCS_CNT_ALL   = 2'h0;
    localparam logic [1:0] CMCS_CNT_ODD   = 2'h1;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CMCS_CLK_MHZ      = 25;
    localparam int CMCS_ACQ_STEP_NS  = 400;
    localparam int CMCS_ACQ_STEP_CYC = (CMCS_ACQ_STEP_NS * CMCS_CLK_MHZ) / 1000;
    localparam int CMCS_CONV_NS      = 695;
    localparam int CMCS_CONV_CYC     = (CMCS_CONV_NS * CMCS_CLK_MHZ + 999) / 1000;
    localparam int CMCS_RETURN_US    = 80;
    localparam int CMCS_RETURN_CYC   = CMCS_RETURN_US * CMCS_CLK_MHZ;
    localparam logic [11:0] CMCS_SELFTEST_CODE = 12'h3d4;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        CMCS_IDLE   = 3'b000,
        CMCS_ACQ    = 3'b001,
        CMCS_CONV   = 3'b010,
        CMCS_RETURN = 3'b011,
        CMCS_DOWN   = 3'b100
    } cmcs_state_t;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } cmcs_bus_req_t;
endpackage

// *** cmcs_sequencer.sv ***
// module: conversion sequencer with register port
//
// Our own choices: the strobed register port and the register offsets.
module cmcs_sequencer
    import cmcs_pkg::*;
(
    input  wire logic          clk_sys_i,                // system clock
    input  wire logic          sys_rst_i,                // sync reset, high
    input  wire logic          clk_en_i,                 // clock enable
    input  wire cmcs_bus_req_t bus_i,                    // register request
    output logic [15:0]        rdata_o,                  // read data
    input  wire logic          full_shutdown_request_n_i,// shutdown pin, low
    input  wire logic [11:0]   adc_code_i,               // converter result
    output logic               hv_mux_active_o,          // high mux owns adc
    output logic               lv_mux_active_o,          // low mux owns adc
    output logic [2:0]         chan_sel_o,               // channel index
    output logic               selftest_sel_o,           // band-gap input
    output logic               sample_o,                 // conversion pulse
    output logic               thermistor_termination_pin_o, // termination on
    output logic               powered_down_o            // hardware power-down
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] alert_reg;
    logic [11:0] result_reg;
    logic [11:0] selftest_result_reg;
    logic [5:0]  aux_done_reg;
    logic [1:0]  pin_sync_reg;
    logic        pin_prev_reg;
    logic        selftest_reg;
    logic        aux_phase_reg;
    logic [2:0]  chan_reg;
    logic [11:0] timer_reg;
    cmcs_state_t state_reg;
    logic        start_req;
    logic        test_req;
    logic        fall_edge;
    logic        last_conv;
    logic [11:0] acq_cycles;
    logic [2:0]  next_aux;
    logic        ready;
    assign start_req  = bus_i.wr && bus_i.addr == CMCS_ADDR_CMD && bus_i.wdata[CMCS_CMD_START];
    assign test_req   = bus_i.wr && bus_i.addr == CMCS_ADDR_CMD && bus_i.wdata[CMCS_CMD_TEST];
    assign fall_edge  = pin_prev_reg && !pin_sync_reg[1];
    assign ready      = state_reg == CMCS_IDLE;
    // acquisition 400 ns steps by field value
    assign acq_cycles = 12'(CMCS_ACQ_STEP_CYC) * 12'({1'b0, ctrl_reg[CMCS_ACQ_MSB:CMCS_ACQ_LSB]} + 3'h1);
    // auxiliary step: all, or odd inputs only
    assign next_aux   = (ctrl_reg[CMCS_CNT_MSB:CMCS_CNT_LSB] == CMCS_CNT_ODD) ? chan_reg + 3'h2 : chan_reg + 3'h1;
    always_comb begin
        last_conv = 1'b0;
        if (selftest_reg) begin
            last_conv = 1'b1;
        end else if (!aux_phase_reg) begin
            // cells always all six, aux only if selected
            last_conv = chan_reg == 3'h0 && ctrl_reg[CMCS_CNT_MSB] && !ctrl_reg[CMCS_CNT_LSB];
            if (chan_reg == 3'h0 && ctrl_reg[CMCS_CNT_MSB:CMCS_CNT_LSB] == 2'h3) begin
                last_conv = 1'b1;
            end
        end else begin
            last_conv = next_aux > 3'h5 || next_aux < chan_reg;
        end
    end
    // ----------------------------------------
    // shutdown pin sync
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_sync_reg <= 2'h3;
            pin_prev_reg <= 1'b1;
        end else if (clk_en_i) begin
            pin_sync_reg <= {pin_sync_reg[0], full_shutdown_request_n_i};
            pin_prev_reg <= pin_sync_reg[1];
        end
    end
    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl_reg  <= CMCS_CTRL_RST;
            alert_reg <= CMCS_ALERT_RST;
        end else if (clk_en_i && bus_i.wr) begin
            if (bus_i.addr == CMCS_ADDR_CTRL) begin
                ctrl_reg <= bus_i.wdata;
            end
            if (bus_i.addr == CMCS_ADDR_ALERT) begin
                alert_reg <= bus_i.wdata;
            end
        end
    end
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg     <= CMCS_IDLE;
            chan_reg      <= 3'h5;
            aux_phase_reg <= 1'b0;
            selftest_reg  <= 1'b0;
            timer_reg     <= 12'h000;
        end else if (clk_en_i) begin
            if (fall_edge) begin
                // drop low mux and any self-test on power-down; high mux reselects the top cell
                state_reg     <= CMCS_DOWN;
                aux_phase_reg <= 1'b0;
                selftest_reg  <= 1'b0;
                chan_reg      <= 3'h5;
            end else begin
                case (state_reg)
                    CMCS_IDLE: begin
                        // only idle accepts a start
                        if (start_req || test_req) begin
                            state_reg     <= CMCS_ACQ;
                            selftest_reg  <= test_req;
                            chan_reg      <= 3'h5;
                            aux_phase_reg <= 1'b0;
                            timer_reg     <= acq_cycles;
                        end
                    end
                    CMCS_ACQ: begin
                        if (timer_reg <= 12'h001) begin
                            state_reg <= CMCS_CONV;
                            timer_reg <= 12'(CMCS_CONV_CYC);
                        end else begin
                            timer_reg <= timer_reg - 12'h001;
                        end
                    end
                    CMCS_CONV: begin
                        if (timer_reg <= 12'h001) begin
                            if (last_conv) begin
                                state_reg     <= CMCS_RETURN;
                                aux_phase_reg <= 1'b0;
                                chan_reg      <= 3'h5;
                                timer_reg     <= 12'(CMCS_RETURN_CYC);
                            end else begin
                                state_reg <= CMCS_ACQ;
                                timer_reg <= acq_cycles;
                                if (!aux_phase_reg && chan_reg == 3'h0) begin
                                    aux_phase_reg <= 1'b1;
                                    chan_reg      <= 3'h0;
                                end else if (aux_phase_reg) begin
                                    chan_reg <= next_aux;
                                end else begin
                                    chan_reg <= chan_reg - 3'h1;
                                end
                            end
                        end else begin
                            timer_reg <= timer_reg - 12'h001;
                        end
                    end
                    CMCS_RETURN: begin
                        // re-arm high mux on the top cell
                        if (timer_reg <= 12'h001) begin
                            state_reg    <= CMCS_IDLE;
                            selftest_reg <= 1'b0;
                        end else begin
                            timer_reg <= timer_reg - 12'h001;
                        end
                    end
                    CMCS_DOWN: begin
                        if (pin_sync_reg[1]) begin
                            state_reg <= CMCS_IDLE;
                        end
                    end
                    default: state_reg <= CMCS_IDLE;
                endcase
            end
        end
    end
    // ----------------------------------------
    // results
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            result_reg          <= 12'h000;
            selftest_result_reg <= 12'h000;
            aux_done_reg        <= 6'h00;
        end else if (clk_en_i && state_reg == CMCS_CONV && timer_reg <= 12'h001) begin
            result_reg <= adc_code_i;
            if (selftest_reg) begin
                selftest_result_reg <= adc_code_i;
            end
            if (aux_phase_reg) begin
                // excluded channels never flag for limit checks
                aux_done_reg[chan_reg] <= !((chan_reg == 3'h4 && alert_reg[0]) ||
                                            (chan_reg == 3'h2 && alert_reg[1]));
            end
        end
    end
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rdata_o                      <= 16'h0000;
            hv_mux_active_o              <= 1'b1;
            lv_mux_active_o              <= 1'b0;
            chan_sel_o                   <= 3'h5;
            selftest_sel_o               <= 1'b0;
            sample_o                     <= 1'b0;
            thermistor_termination_pin_o <= 1'b0;
            powered_down_o               <= 1'b0;
        end else if (clk_en_i) begin
            hv_mux_active_o              <= !aux_phase_reg && !selftest_reg;
            lv_mux_active_o              <= aux_phase_reg && !fall_edge;
            chan_sel_o                   <= chan_reg;
            selftest_sel_o               <= selftest_reg;
            sample_o                     <= state_reg == CMCS_ACQ && timer_reg <= 12'h001 && !fall_edge;
            thermistor_termination_pin_o <= ctrl_reg[CMCS_TERM_BIT];
            powered_down_o               <= state_reg == CMCS_DOWN || fall_edge;
            rdata_o                      <= 16'h0000;
            if (bus_i.rd) begin
                case (bus_i.addr)
                    CMCS_ADDR_CTRL:   rdata_o <= ctrl_reg;
                    CMCS_ADDR_ALERT:  rdata_o <= alert_reg;
                    CMCS_ADDR_STATUS: rdata_o <= {7'h00, aux_done_reg, state_reg == CMCS_RETURN,
                                                  selftest_reg, ready};
                    CMCS_ADDR_RESULT: rdata_o <= {4'h0, selftest_reg ? selftest_result_reg : result_reg};
                    default:          rdata_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// *** cmcs_adc_model.sv ***
// converter front-end model answering the sequencer's channel selects
module cmcs_adc_model
    import cmcs_pkg::*;
#(
    parameter logic [11:0] BANDGAP_CODE = 12'h3d4
)
(
    input  wire logic [2:0]  chan_sel_i,     // selected channel
    input  wire logic        selftest_sel_i, // band-gap selected
    input  wire logic        lv_i,           // auxiliary phase
    output logic      [11:0] adc_code_o      // converter result
);
    // band-gap code on self-test, else a per-channel pattern
    assign adc_code_o = selftest_sel_i ? BANDGAP_CODE : {8'h10, lv_i, chan_sel_i};
endmodule

// *** cmcs_sequencer_chk.sv ***
// checker: port-level properties of the conversion sequencer
module cmcs_sequencer_chk
    import cmcs_pkg::*;
(
    input wire logic          clk_sys_i,
    input wire logic          sys_rst_i,
    input wire logic          clk_en_i,
    input wire cmcs_bus_req_t bus_i,
    input wire logic [15:0]   rdata_o,
    input wire logic          full_shutdown_request_n_i,
    input wire logic [11:0]   adc_code_i,
    input wire logic          hv_mux_active_o,
    input wire logic          lv_mux_active_o,
    input wire logic [2:0]    chan_sel_o,
    input wire logic          selftest_sel_o,
    input wire logic          sample_o,
    input wire logic          thermistor_termination_pin_o,
    input wire logic          powered_down_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_mux_excl: assert property (!(hv_mux_active_o && lv_mux_active_o))
        else $error("both multiplexers own the converter");
    a_sample_pulse: assert property (sample_o && clk_en_i |=> !sample_o)
        else $error("sample pulse longer than one cycle");
    a_term_follow: assert property (clk_en_i && bus_i.wr && bus_i.addr == CMCS_ADDR_CTRL
        |-> ##2 thermistor_termination_pin_o == $past(bus_i.wdata[CMCS_TERM_BIT], 2))
        else $error("termination pin off");
    a_rdata_idle: assert property (clk_en_i && !bus_i.rd |=> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    a_unmapped_rd: assert property (clk_en_i && bus_i.rd && bus_i.addr > CMCS_ADDR_CMD
        |=> rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_pd_enter: assert property ($fell(full_shutdown_request_n_i) |-> ##[1:4] powered_down_o)
        else $error("power-down not entered");
    a_pd_quiet: assert property (powered_down_o |-> !sample_o && !lv_mux_active_o)
        else $error("activity while powered down");
    a_back_to_top: assert property ($fell(lv_mux_active_o)
        |-> ##[0:2] (hv_mux_active_o && chan_sel_o == 3'h5)) else $error("no return to top cell");
    a_aux_range: assert property (lv_mux_active_o |-> chan_sel_o <= 3'h5)
        else $error("auxiliary index out of range");
    c_aux_sample: cover property (sample_o && lv_mux_active_o);
    c_pd: cover property ($rose(powered_down_o));
    c_selftest: cover property (selftest_sel_o && sample_o);
endmodule

// *** tb_top.sv ***
// testbench: register-port scenarios for the conversion sequencer
module tb_top
    import cmcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i, sys_rst_i, pin_n, hv, lv, sel, samp, term, pd, en;
    cmcs_bus_req_t bus;
    logic [15:0] rdat, d;
    logic [11:0] code;
    logic [2:0]  chan;
    int          miscompares, compares;

    cmcs_sequencer DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(en), .bus_i(bus),
        .rdata_o(rdat), .full_shutdown_request_n_i(pin_n), .adc_code_i(code), .hv_mux_active_o(hv),
        .lv_mux_active_o(lv), .chan_sel_o(chan), .selftest_sel_o(sel), .sample_o(samp),
        .thermistor_termination_pin_o(term), .powered_down_o(pd));
    cmcs_adc_model u_adc (.chan_sel_i(chan), .selftest_sel_i(sel), .lv_i(lv), .adc_code_o(code));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1 v = rdat;
    endtask
    // ----------------------------------------
    // one full sequence with a given count and acquisition code
    // ----------------------------------------
    task automatic run_seq(input logic [1:0] cnt);
        logic [4:0] exp_q[$];
        int n, last;
        n = 0;
        last = 0;
        for (int i = 0; i < 6; i++) exp_q.push_back({2'b10, 3'(5 - i)});
        for (int i = 0; i < 6; i++) begin
            if (cnt == 2'h0 || (cnt == 2'h1 && i % 2 == 0)) exp_q.push_back({2'b01, 3'(i)});
        end
        wr(CMCS_ADDR_CTRL, {cnt, cnt, 5'h00, cnt, 1'b0, cnt == 2'h3, 3'h0});
        @(posedge clk_sys_i);
        #1 check(16'(term), 16'(cnt == 2'h3));
        wr(CMCS_ADDR_CMD, 16'h0001);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk_sys_i);
            if (i == 40) bus <= '{addr: CMCS_ADDR_CMD, wdata: 16'h0001, wr: 1'b1, rd: 1'b0};
            else bus.wr <= 1'b0;
            #1;
            if (samp === 1'b1) begin
                if (n < exp_q.size()) check(16'({hv, lv, chan}), 16'(exp_q[n]));
                if (n > 0 && n < 6) check(16'(i - last), 16'(10 * (cnt + 1) + 18));
                last = i;
                n++;
            end
        end
        check(16'(n), 16'(exp_q.size()));
        check(16'({hv, lv, chan}), 16'h0015);
        rd(CMCS_ADDR_STATUS, d);
        check(d & 16'h0001, 16'h0001);
        check(d & 16'h01f8, 16'h0158);
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #(40 * 60000);
        miscompares++;
        end_sim();
    end
    initial begin
        miscompares = 0;
        compares = 0;
        sys_rst_i = 1'b1;
        pin_n = 1'b1;
        en = 1'b1;
        bus = '{addr: 4'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1 check(16'({hv, lv, chan, sel, samp, term, pd}), 16'h0150);
        rd(CMCS_ADDR_CTRL, d);
        check(d, 16'h0000);
        wr(4'h9, 16'hffff);
        rd(4'h9, d);
        check(d, 16'h0000);
        rd(CMCS_ADDR_ALERT, d);
        check(d, 16'h0000);
        wr(CMCS_ADDR_ALERT, 16'h0003);
        rd(CMCS_ADDR_ALERT, d);
        check(d & 16'h0003, 16'h0003);
        for (int c = 0; c < 4; c++) run_seq(2'(c));
        wr(CMCS_ADDR_CMD, 16'h0002);
        repeat (5) @(posedge clk_sys_i);
        #1 check(16'({hv, lv, sel}), 16'h0001);
        repeat (2200) @(posedge clk_sys_i);
        rd(CMCS_ADDR_RESULT, d);
        check(d & 16'h0fff, 16'h03d4);
        @(posedge clk_sys_i);
        pin_n <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1 check(16'(pd), 16'h0001);
        @(posedge clk_sys_i);
        pin_n <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        #1 check(16'(pd), 16'h0000);
        // write while frozen must not land
        @(posedge clk_sys_i);
        en <= 1'b0;
        wr(CMCS_ADDR_CTRL, 16'h00a5);
        en <= 1'b1;
        rd(CMCS_ADDR_CTRL, d);
        check(d, 16'hf068);
        end_sim();
    end
endmodule

bind cmcs_sequencer cmcs_sequencer_chk u_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .full_shutdown_request_n_i(full_shutdown_request_n_i), .adc_code_i(adc_code_i),
    .hv_mux_active_o(hv_mux_active_o), .lv_mux_active_o(lv_mux_active_o), .chan_sel_o(chan_sel_o),
    .selftest_sel_o(selftest_sel_o), .sample_o(sample_o),
    .thermistor_termination_pin_o(thermistor_termination_pin_o), .powered_down_o(powered_down_o));
